// file: hw/pom_pkg.sv
// Shared constants and types of the receive VC-4 path overhead monitor.
// Assumes a byte-wide register map reached over a 32-bit Avalon-MM slave.
package pom_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Register indices; the bus byte address is four times the index.
    localparam logic [13:0] POM_CTRL_IDX = 14'h1183;
    localparam logic [13:0] POM_STAT_HI_IDX = 14'h1186;
    localparam logic [13:0] POM_STAT_LO_IDX = 14'h1187;
    localparam logic [13:0] POM_THRD_IDX = 14'h1193;
    localparam logic [13:0] POM_TRACE_CTL_IDX = 14'h11a3;
    localparam logic [13:0] POM_TRACE_EXP_BASE = 14'h1240;
    localparam logic [7:0] POM_CTRL_RESET = 8'h00;
    localparam logic [3:0] POM_THRD_RESET = 4'h0;
    localparam logic [2:0] POM_TRACE_CTL_RESET = 3'h0;

    ////////////////////////////////////////////////////////////////////////
    // Field positions of the control byte.
    localparam int POM_CTL_FILTER = 3;
    localparam int POM_CTL_RDI_STYLE = 2;
    localparam int POM_CTL_REI_MODE = 1;
    localparam int POM_CTL_B3_MODE = 0;
    // Field positions of the trace control byte.
    localparam int POM_TCTL_LEN_LO = 0;
    localparam int POM_TCTL_LONG_STABLE = 2;
    // Field positions of the status bytes.
    localparam int POM_ST_TRACE_MISMATCH = 7;
    localparam int POM_ST_LABEL_UNSTABLE = 6;
    localparam int POM_ST_UNEQUIPPED = 5;
    localparam int POM_ST_REMOTE_DEFECT = 3;
    localparam int POM_ST_TRACE_UNSTABLE = 0;
    // G1 single-bit remote defect position and enhanced field.
    localparam int POM_G1_RDI_BIT = 5;

    ////////////////////////////////////////////////////////////////////////
    // Counts, in containers or messages.
    localparam logic [1:0] POM_PTR_GUARD = 2'h3;
    localparam logic [3:0] POM_TRACE_UNSTABLE_LIMIT = 4'h8;
    localparam logic [2:0] POM_LABEL_UNSTABLE_LIMIT = 3'h5;
    localparam logic [2:0] POM_UNEQ_PERSIST = 3'h5;
    localparam logic [2:0] POM_STABLE_SHORT = 3'h3;
    localparam logic [2:0] POM_STABLE_LONG = 3'h5;
    localparam logic [2:0] POM_MATCH_NUM = 3'h4;
    localparam logic [2:0] POM_MATCH_DEN = 3'h5;
    localparam logic [7:0] POM_C2_UNEQUIPPED = 8'h00;
    localparam logic [2:0] POM_ERDI_A = 3'b010;
    localparam logic [2:0] POM_ERDI_B = 3'b101;
    localparam logic [2:0] POM_ERDI_C = 3'b110;

    // Trace length selection codes and the lengths they stand for.
    typedef enum logic [1:0] {
        POM_TLEN_1 = 2'b00,
        POM_TLEN_16 = 2'b01,
        POM_TLEN_64 = 2'b10
    } pom_tlen_e;
    localparam logic [6:0] POM_LEN_1 = 7'h01;
    localparam logic [6:0] POM_LEN_16 = 7'h10;
    localparam logic [6:0] POM_LEN_64 = 7'h40;

    // One container's worth of overhead from the section/line processor.
    typedef struct packed {
        logic valid;
        logic ptr_inc;
        logic ptr_dec;
        logic [7:0] g1;
        logic [7:0] c2;
        logic [7:0] j1;
        logic [7:0] b3_diff;
    } pom_container_s;

endpackage

// file: hw/pom_monitor.sv
// Receive VC-4 path overhead monitor: defect status and error tallies.
// Assumes one container per valid pulse, all inputs synchronous to clk.
//
// Chosen here: register access over Avalon-MM.
`timescale 1ns/10ps

module pom_monitor
    import pom_pkg::*;
#(
    parameter int TRACE_DEPTH = 64,
    parameter int CNT_W = 32
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [15:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire pom_container_s rx,
    output logic ptr_adj_inc,
    output logic ptr_adj_dec,
    output logic [CNT_W-1:0] b3_err_count,
    output logic [CNT_W-1:0] rei_err_count
);

    ////////////////////////////////////////////////////////////////////////
    // Bus slave: one wait cycle, then the access completes.
    logic wait_q;
    logic [31:0] rdata_q;
    logic [7:0] ctrl_q;
    logic [3:0] thrd_q;
    logic [2:0] tctl_q;
    logic [7:0] exp_mem [TRACE_DEPTH];
    logic [7:0] prev_mem [TRACE_DEPTH];
    logic [7:0] rd_byte;
    logic [7:0] stat_hi;
    logic [7:0] stat_lo;

    // Decode; the request is held stable until waitrequest falls.
    wire req = avs_read | avs_write;
    wire done = req & ~wait_q;
    wire [13:0] idx = avs_address[15:2];
    wire wr_ok = done & avs_write & avs_byteenable[0];
    wire hit_ctrl = idx == POM_CTRL_IDX;
    wire hit_hi = idx == POM_STAT_HI_IDX;
    wire hit_lo = idx == POM_STAT_LO_IDX;
    wire hit_thrd = idx == POM_THRD_IDX;
    wire hit_tctl = idx == POM_TRACE_CTL_IDX;
    wire hit_exp = idx[13:6] == POM_TRACE_EXP_BASE[13:6];
    wire [5:0] exp_sel = idx[5:0];

    // Read mux; unmapped addresses read as zero, status ignores writes.
    always_comb begin
        rd_byte = 8'h00;
        if (hit_ctrl) begin
            rd_byte = ctrl_q;
        end
        if (hit_hi) begin
            rd_byte = stat_hi;
        end
        if (hit_lo) begin
            rd_byte = stat_lo;
        end
        if (hit_thrd) begin
            rd_byte = {4'h0, thrd_q};
        end
        if (hit_tctl) begin
            rd_byte = {5'h00, tctl_q};
        end
        if (hit_exp) begin
            rd_byte = exp_mem[exp_sel];
        end
    end

    // Waitrequest drops for exactly one cycle per request.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wait_q <= 1'b1;
            rdata_q <= 32'h0000_0000;
        end else begin
            wait_q <= ~(req & wait_q);
            if (req & wait_q) begin
                rdata_q <= {24'h00_0000, rd_byte};
            end
        end
    end

    // Configuration registers.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ctrl_q <= POM_CTRL_RESET;
            thrd_q <= POM_THRD_RESET;
            tctl_q <= POM_TRACE_CTL_RESET;
        end else if (wr_ok) begin
            if (hit_ctrl) ctrl_q <= {4'h0, avs_writedata[3:0]};
            if (hit_thrd) thrd_q <= avs_writedata[3:0];
            if (hit_tctl) tctl_q <= avs_writedata[2:0];
        end
    end

    // Expected trace memory; no reset, software loads it before use.
    always_ff @(posedge clk) begin
        if (wr_ok & hit_exp) begin
            exp_mem[exp_sel] <= avs_writedata[7:0];
        end
    end

    assign avs_waitrequest = wait_q;
    assign avs_readdata = rdata_q;

    ////////////////////////////////////////////////////////////////////////
    // Pointer adjustment guard window.
    logic [1:0] since_q;
    logic inc_q;
    logic dec_q;
    wire filt_on = ctrl_q[POM_CTL_FILTER];
    wire guard = filt_on & (since_q < POM_PTR_GUARD);
    wire adj_seen = rx.valid & (rx.ptr_inc | rx.ptr_dec);
    wire adj_take = adj_seen & ~guard;

    // Frames since the last accepted move, saturating at the guard.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            since_q <= POM_PTR_GUARD;
            inc_q <= 1'b0;
            dec_q <= 1'b0;
        end else begin
            inc_q <= adj_take & rx.ptr_inc;
            dec_q <= adj_take & rx.ptr_dec & ~rx.ptr_inc;
            if (adj_take) begin
                since_q <= 2'h0;
            end else if (rx.valid && since_q != POM_PTR_GUARD) begin
                since_q <= since_q + 2'h1;
            end
        end
    end

    assign ptr_adj_inc = inc_q;
    assign ptr_adj_dec = dec_q;

    ////////////////////////////////////////////////////////////////////////
    // Error tallies. Counters wrap; software samples them elsewhere.
    logic [CNT_W-1:0] b3_q;
    logic [CNT_W-1:0] rei_q;
    logic [3:0] b3_bits;
    wire b3_frame = ctrl_q[POM_CTL_B3_MODE];
    wire rei_frame = ctrl_q[POM_CTL_REI_MODE];

    // Population count of the B3 difference byte.
    always_comb begin
        b3_bits = 4'h0;
        for (int i = 0; i < 8; i++) begin
            b3_bits = b3_bits + {3'h0, rx.b3_diff[i]};
        end
    end

    wire [3:0] b3_inc = b3_frame ? {3'h0, |rx.b3_diff} : b3_bits;
    wire [3:0] rei_inc = rei_frame ? {3'h0, |rx.g1[3:0]} : rx.g1[3:0];

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            b3_q <= '0;
            rei_q <= '0;
        end else if (rx.valid) begin
            b3_q <= b3_q + CNT_W'(b3_inc);
            rei_q <= rei_q + CNT_W'(rei_inc);
        end
    end

    assign b3_err_count = b3_q;
    assign rei_err_count = rei_q;

    ////////////////////////////////////////////////////////////////////////
    // Remote defect: a changed indication must persist for the threshold.
    logic rdi_q;
    logic [3:0] rdi_run_q;
    wire [2:0] g1_hi = {rx.g1[5], rx.g1[6], rx.g1[7]};
    wire erdi = (g1_hi == POM_ERDI_A) | (g1_hi == POM_ERDI_B)
        | (g1_hi == POM_ERDI_C);
    wire rdi_ind = ctrl_q[POM_CTL_RDI_STYLE] ? erdi
        : rx.g1[POM_G1_RDI_BIT];
    // A zero threshold is treated as one so the defect can still follow.
    wire [3:0] thr_eff = (thrd_q == 4'h0) ? 4'h1 : thrd_q;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rdi_q <= 1'b0;
            rdi_run_q <= 4'h0;
        end else if (rx.valid) begin
            if (rdi_ind == rdi_q) begin
                rdi_run_q <= 4'h0;
            end else if (rdi_run_q + 4'h1 >= thr_eff) begin
                rdi_q <= rdi_ind;
                rdi_run_q <= 4'h0;
            end else begin
                rdi_run_q <= rdi_run_q + 4'h1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Unequipped and label instability, both watching C2.
    logic uneq_q;
    logic [2:0] uneq_run_q;
    logic [7:0] c2_prev_q;
    logic [2:0] lbl_cnt_q;
    logic [2:0] lbl_same_q;
    logic lbl_q;
    wire c2_zero = rx.c2 == POM_C2_UNEQUIPPED;
    wire c2_diff = rx.c2 != c2_prev_q;
    wire [2:0] stable_n = tctl_q[POM_TCTL_LONG_STABLE] ? POM_STABLE_LONG
        : POM_STABLE_SHORT;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            uneq_q <= 1'b0;
            uneq_run_q <= 3'h0;
        end else if (rx.valid) begin
            if (c2_zero == uneq_q) begin
                uneq_run_q <= 3'h0;
            end else if (uneq_run_q + 3'h1 >= POM_UNEQ_PERSIST) begin
                uneq_q <= c2_zero;
                uneq_run_q <= 3'h0;
            end else begin
                uneq_run_q <= uneq_run_q + 3'h1;
            end
        end
    end

    // A new C2 value starts its own run of one identical container.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            c2_prev_q <= 8'h00;
            lbl_cnt_q <= 3'h0;
            lbl_same_q <= 3'h0;
            lbl_q <= 1'b0;
        end else if (rx.valid) begin
            c2_prev_q <= rx.c2;
            if (c2_diff) begin
                lbl_same_q <= 3'h1;
                if (lbl_cnt_q != POM_LABEL_UNSTABLE_LIMIT) begin
                    lbl_cnt_q <= lbl_cnt_q + 3'h1;
                end
                if (lbl_cnt_q + 3'h1 >= POM_LABEL_UNSTABLE_LIMIT) begin
                    lbl_q <= 1'b1;
                end
            end else if (lbl_same_q + 3'h1 >= stable_n) begin
                lbl_same_q <= stable_n;
                lbl_cnt_q <= 3'h0;
                lbl_q <= 1'b0;
            end else begin
                lbl_same_q <= lbl_same_q + 3'h1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Trace: one J1 byte per container, judged at the end of a message.
    logic [5:0] pos_q;
    logic [6:0] miss_q;
    logic diff_q;
    logic tim_q;
    logic [3:0] tr_cnt_q;
    logic [2:0] tr_same_q;
    logic tr_unst_q;
    logic [6:0] tlen;
    wire tlen_sel_ok = tctl_q[1:0] != 2'b11;

    always_comb begin
        unique case (pom_tlen_e'(tlen_sel_ok ? tctl_q[1:0] : 2'b00))
            POM_TLEN_1: tlen = POM_LEN_1;
            POM_TLEN_16: tlen = POM_LEN_16;
            POM_TLEN_64: tlen = POM_LEN_64;
            default: tlen = POM_LEN_1;
        endcase
    end

    wire byte_miss = rx.j1 != exp_mem[pos_q];
    wire byte_diff = rx.j1 != prev_mem[pos_q];
    wire msg_end = {1'b0, pos_q} == tlen - 7'h01;
    wire [6:0] miss_all = miss_q + {6'h00, byte_miss};
    wire [6:0] hits = tlen - miss_all;
    wire msg_diff = diff_q | byte_diff;
    // Eighty percent: hits * 5 >= len * 4, widened to avoid overflow.
    wire good80 = ({3'h0, hits} * {7'h00, POM_MATCH_DEN})
        >= ({3'h0, tlen} * {7'h00, POM_MATCH_NUM});

    // Previous message copy, used to spot inconsistent repeats.
    always_ff @(posedge clk) begin
        if (rx.valid) begin
            prev_mem[pos_q] <= rx.j1;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pos_q <= 6'h00;
            miss_q <= 7'h00;
            diff_q <= 1'b0;
            tim_q <= 1'b0;
        end else if (rx.valid) begin
            if (msg_end) begin
                pos_q <= 6'h00;
                miss_q <= 7'h00;
                diff_q <= 1'b0;
                if (hits == 7'h00) begin
                    tim_q <= 1'b1;
                end else if (good80) begin
                    tim_q <= 1'b0;
                end
            end else begin
                pos_q <= pos_q + 6'h01;
                miss_q <= miss_all;
                diff_q <= msg_diff;
            end
        end
    end

    // Instability counter saturates at its limit.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            tr_cnt_q <= 4'h0;
            tr_same_q <= 3'h0;
            tr_unst_q <= 1'b0;
        end else if (rx.valid & msg_end) begin
            if (msg_diff) begin
                tr_same_q <= 3'h1;
                if (tr_cnt_q != POM_TRACE_UNSTABLE_LIMIT) begin
                    tr_cnt_q <= tr_cnt_q + 4'h1;
                end
                if (tr_cnt_q + 4'h1 >= POM_TRACE_UNSTABLE_LIMIT) begin
                    tr_unst_q <= 1'b1;
                end
            end else if (tr_same_q + 3'h1 >= stable_n) begin
                tr_same_q <= stable_n;
                tr_cnt_q <= 4'h0;
                tr_unst_q <= 1'b0;
            end else begin
                tr_same_q <= tr_same_q + 3'h1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Status bytes; bits owned by neighbouring logic read as zero.
    always_comb begin
        stat_hi = 8'h00;
        stat_hi[POM_ST_TRACE_UNSTABLE] = tr_unst_q;
        stat_lo = 8'h00;
        stat_lo[POM_ST_TRACE_MISMATCH] = tim_q;
        stat_lo[POM_ST_LABEL_UNSTABLE] = lbl_q;
        stat_lo[POM_ST_UNEQUIPPED] = uneq_q;
        stat_lo[POM_ST_REMOTE_DEFECT] = rdi_q;
    end

endmodule // pom_monitor

// file: tb/pom_monitor_props.sv
// Concurrent checks on the path overhead monitor's ports.
// Assumes a bind from the bench; it sees the top module's ports only.
`timescale 1ns/10ps

module pom_monitor_props
    import pom_pkg::*;
#(
    parameter int CNT_W = 32
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [15:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire pom_container_s rx,
    input wire logic ptr_adj_inc,
    input wire logic ptr_adj_dec,
    input wire logic [CNT_W-1:0] b3_err_count,
    input wire logic [CNT_W-1:0] rei_err_count
);

    ////////////////////////////////////////////////////////////////////////
    // One clock domain; the asynchronous reset disables every check.
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    // A taken request is answered after exactly one wait cycle.
    a_wait_one_cycle: assert property ((avs_read || avs_write) &&
        avs_waitrequest |=> !avs_waitrequest)
        else $error("bus answer late");
    // The answer stands one cycle and never comes unasked.
    a_wait_low_once: assert property (!avs_waitrequest |=>
        avs_waitrequest) else $error("wait low too long");
    a_wait_has_req: assert property (!avs_waitrequest |->
        $past(avs_read || avs_write)) else $error("answer without request");
    // Only the low byte of a read carries data.
    a_read_upper_zero: assert property (avs_read && !avs_waitrequest |->
        avs_readdata[31:8] == 24'h000000) else $error("upper read bits");
    a_stat_hi_unused: assert property (avs_read && !avs_waitrequest &&
        avs_address[15:2] == POM_STAT_HI_IDX |->
        avs_readdata[7:1] == 7'h00) else $error("unused status bits set");

    ////////////////////////////////////////////////////////////////////////
    // Pointer pulses only follow a container that carried the move.
    a_inc_has_cause: assert property (ptr_adj_inc |->
        $past(rx.valid && rx.ptr_inc)) else $error("stray increment");
    a_dec_has_cause: assert property (ptr_adj_dec |->
        $past(rx.valid && rx.ptr_dec && !rx.ptr_inc))
        else $error("stray decrement");

    // A clean container leaves a tally alone; an errored one adds a bounded
    // amount, whichever mode is selected.
    a_b3_clean_hold: assert property ($past(!rx.valid ||
        rx.b3_diff == 8'h00) |-> $stable(b3_err_count))
        else $error("parity tally moved");
    a_b3_step_size: assert property ($past(rx.valid &&
        rx.b3_diff != 8'h00) |-> b3_err_count - $past(b3_err_count) >= 1 &&
        b3_err_count - $past(b3_err_count) <= 8)
        else $error("parity tally step");
    a_rei_clean_hold: assert property ($past(!rx.valid ||
        rx.g1[3:0] == 4'h0) |-> $stable(rei_err_count))
        else $error("remote error tally moved");
    a_rei_step_size: assert property ($past(rx.valid &&
        rx.g1[3:0] != 4'h0) |-> rei_err_count - $past(rei_err_count) >= 1
        && rei_err_count - $past(rei_err_count) <= 15)
        else $error("remote error tally step");

endmodule // pom_monitor_props

// file: tb/pom_rx_source.sv
// Model of the upstream section and line processor feeding containers.
// Assumes the bench calls its tasks from one thread, clocked by clk.
`timescale 1ns/10ps

module pom_rx_source
    import pom_pkg::*;
(
    input wire logic clk,
    output pom_container_s rx
);
    pom_container_s last_q;

    ////////////////////////////////////////////////////////////////////////
    // Quiet line at time zero.
    initial begin
        rx = '0;
        last_q = '0;
    end

    // One container per call; calls in a row give back-to-back valids.
    task automatic send(input logic [7:0] g1, c2, j1, b3,
                        input logic inc, dec);
        @(posedge clk);
        last_q = {1'b1, inc, dec, g1, c2, j1, b3};
        rx <= last_q;
    endtask

    // Idle fields toggle, so stale overhead can never pass for fresh data.
    task automatic idle(input int n);
        repeat (n) begin
            @(posedge clk);
            last_q = ~last_q;
            last_q.valid = 1'b0;
            rx <= last_q;
        end
        @(negedge clk);
    endtask

endmodule // pom_rx_source

// file: tb/pom_monitor_bench.sv
// Self-checking bench for the path overhead monitor.
// Assumes the container source model and the property checker.
`timescale 1ns/10ps

module pom_monitor_bench
    import pom_pkg::*;
;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic [15:0] avs_address = 16'h0000;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h00000000;
    logic [3:0] avs_byteenable = 4'hf;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    pom_container_s rx;
    logic ptr_adj_inc;
    logic ptr_adj_dec;
    logic [31:0] b3_err_count;
    logic [31:0] rei_err_count;
    int err_count = 0;
    int num_checks = 0;
    int inc_seen = 0;
    int dec_seen = 0;

    ////////////////////////////////////////////////////////////////////////
    // Clock and a tally of accepted pointer moves.
    always #2 clk = ~clk;
    always @(posedge clk) begin
        if (ptr_adj_inc === 1'b1) inc_seen++;
        if (ptr_adj_dec === 1'b1) dec_seen++;
    end

    pom_monitor dut (.clk(clk), .rstn(rstn), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .rx(rx), .ptr_adj_inc(ptr_adj_inc), .ptr_adj_dec(ptr_adj_dec),
        .b3_err_count(b3_err_count), .rei_err_count(rei_err_count));
    pom_rx_source src (.clk(clk), .rx(rx));

    ////////////////////////////////////////////////////////////////////////
    // Verdict, comparison and bus tasks.
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, g);
        num_checks++;
        if (g !== e) begin
            err_count++;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask

    // The request holds until the edge that sees waitrequest low.
    task automatic bus(input logic w, input logic [13:0] idx,
                       input logic [7:0] wd, output logic [31:0] rd);
        int n;
        n = 0;
        @(posedge clk);
        avs_address <= {idx, 2'b00};
        avs_write <= w;
        avs_read <= !w;
        avs_writedata <= {24'h000000, wd};
        // Waitrequest is judged at the rising edge, before it updates.
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 64);
        if (avs_waitrequest !== 1'b0) begin
            err_count++;
            tally_and_finish;
        end
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask

    task automatic wr(input logic [13:0] idx, input logic [7:0] d);
        logic [31:0] x;
        bus(1'b1, idx, d, x);
    endtask

    task automatic rd_chk(input string nm, input logic [13:0] idx,
                          input logic [31:0] m, e);
        logic [31:0] x;
        bus(1'b0, idx, 8'h00, x);
        chk(nm, e, x & m);
    endtask

    // Changing values n times raises a flag; a run of three clears it.
    task automatic instab(input bit trc, input int n, input logic [31:0] m,
                          input logic [13:0] idx);
        logic [7:0] v;
        for (int i = 0; i <= n + 1; i++) begin
            v = (i < n) ? 8'(i + 1) : 8'(n);
            src.send(8'h00, trc ? 8'h05 : v, trc ? v : 8'h00, 8'h00, 0, 0);
            src.idle(1);
            rd_chk("instability", idx, m, (i == n - 1 || i == n) ? m : 0);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Main sequence.
    initial begin
        logic [31:0] eb;
        logic [31:0] er;
        int ni;
        logic [7:0] codes [4];
        codes = '{8'h20, 8'h40, 8'ha0, 8'h60};
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        rd_chk("status hi", POM_STAT_HI_IDX, '1, 32'h0);
        rd_chk("control", POM_CTRL_IDX, '1, 32'h0);
        rd_chk("unmapped", 14'h1184, '1, 32'h0);
        // A write without the low byte lane enabled must be ignored.
        avs_byteenable <= 4'he;
        wr(POM_CTRL_IDX, 8'h0f);
        avs_byteenable <= 4'hf;
        rd_chk("control lane", POM_CTRL_IDX, '1, 32'h0);
        wr(POM_STAT_LO_IDX, 8'hff);
        rd_chk("status lo", POM_STAT_LO_IDX, '1, 32'h0);
        // Tallies per bit, then per frame, on back-to-back containers.
        src.send(8'h09, 8'h00, 8'h00, 8'h0b, 0, 0);
        src.send(8'h0f, 8'h00, 8'h00, 8'hff, 0, 0);
        src.idle(1);
        chk("b3 count", 32'd11, b3_err_count);
        chk("rei count", 32'd24, rei_err_count);
        wr(POM_CTRL_IDX, 8'h03);
        src.send(8'h0f, 8'h00, 8'h00, 8'hff, 0, 0);
        src.send(8'h00, 8'h00, 8'h00, 8'h00, 0, 0);
        src.send(8'h01, 8'h00, 8'h00, 8'h01, 0, 0);
        src.idle(1);
        chk("b3 count", 32'd13, b3_err_count);
        chk("rei count", 32'd26, rei_err_count);
        // Pointer moves with the guard off, then on.
        wr(POM_CTRL_IDX, 8'h00);
        src.send(8'h00, 8'h00, 8'h00, 8'h00, 1, 0);
        src.send(8'h00, 8'h00, 8'h00, 8'h00, 1, 0);
        src.send(8'h00, 8'h00, 8'h00, 8'h00, 0, 1);
        src.idle(2);
        chk("increments", 32'd2, 32'(inc_seen));
        chk("decrements", 32'd1, 32'(dec_seen));
        wr(POM_CTRL_IDX, 8'h08);
        for (int i = 0; i < 9; i++) begin
            src.send(8'h00, 8'h00, 8'h00, 8'h00, i == 3 || i == 4 || i == 8,
                     i == 5);
        end
        src.idle(2);
        chk("increments", 32'd4, 32'(inc_seen));
        chk("decrements", 32'd1, 32'(dec_seen));
        // Unequipped clears after five nonzero labels, returns after five.
        for (int i = 0; i < 10; i++) begin
            src.send(8'h00, i < 5 ? 8'h13 : 8'h00, 8'h00, 8'h00, 0, 0);
            src.idle(1);
            rd_chk("unequipped", POM_STAT_LO_IDX, 32'h20,
                   (i < 4 || i == 9) ? 32'h20 : 32'h0);
        end
        instab(1'b0, 5, 32'h40, POM_STAT_LO_IDX);
        instab(1'b1, 8, 32'h01, POM_STAT_HI_IDX);
        // One-byte trace: no match declares, a full match clears.
        wr(POM_TRACE_EXP_BASE, 8'h5a);
        src.send(8'h00, 8'h05, 8'h33, 8'h00, 0, 0);
        src.idle(1);
        rd_chk("mismatch", POM_STAT_LO_IDX, 32'h80, 32'h80);
        src.send(8'h00, 8'h05, 8'h5a, 8'h00, 0, 0);
        src.idle(1);
        rd_chk("mismatch", POM_STAT_LO_IDX, 32'h80, 32'h0);
        // Remote defect with a threshold of two, every style and code.
        wr(POM_THRD_IDX, 8'h02);
        for (int k = 0; k < 4; k++) begin
            wr(POM_CTRL_IDX, k == 0 ? 8'h00 : 8'h04);
            for (int s = 0; s < 4; s++) begin
                src.send(s < 2 ? (k == 0 ? 8'h40 : 8'h20) : codes[k],
                         8'h05, 8'h5a, 8'h00, 0, 0);
                src.idle(1);
                if (s > 0) rd_chk("remote defect", POM_STAT_LO_IDX,
                    32'h08, s == 3 ? 32'h08 : 32'h0);
            end
        end
        tally_and_finish;
    end

endmodule // pom_monitor_bench

bind pom_monitor pom_monitor_props #(.CNT_W(CNT_W)) u_props (.clk(clk),
    .rstn(rstn), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .rx(rx),
    .ptr_adj_inc(ptr_adj_inc), .ptr_adj_dec(ptr_adj_dec),
    .b3_err_count(b3_err_count), .rei_err_count(rei_err_count));
